// ==== hdl/gmr_clk_div.sv ====
`timescale 1ns/1ps

module gmr_clk_div
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] half_i,
   output logic            clk_o
);

   logic [7:0] cnt_reg;
   logic [7:0] half_eff;

   // ==========================================
   // Clamp so the output never exceeds its limit
   // ==========================================
   always_comb
   begin
      half_eff = (half_i < gmr_pkg::CLK_HALF_MIN) ? gmr_pkg::CLK_HALF_MIN : half_i;
   end

   // Half period counter and toggle
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_reg <= 8'h00;
         clk_o   <= 1'b0;
      end
      else if (cnt_reg >= half_eff - 8'h01)
      begin
         cnt_reg <= 8'h00;
         clk_o   <= ~clk_o;
      end
      else
      begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   a_half_floor : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $changed(clk_o) |=> $stable(clk_o)) // [RL17]
      else $error("clock output toggled on back to back cycles");

endmodule : gmr_clk_div

// ==== hdl/gmr_pkg.sv ====
package gmr_pkg;

   // ==========================================
   // Pin count and groups
   // ==========================================
   localparam int unsigned NUM_PINS  = 16;
   localparam int unsigned GRP_SIZE  = 8;
   localparam int unsigned PIN_A_RI  = 7;   // Fallback wakeup source

   // ==========================================
   // Function codes
   // ==========================================
   typedef enum logic [3:0] {
      F_SERIAL = 4'h0,
      F_GPIO   = 4'h1,
      F_TXLED  = 4'h2,
      F_RXLED  = 4'h3,
      F_TRXLED = 4'h4,
      F_CLK    = 4'h5,
      F_SUSP   = 4'h6,
      F_CFG    = 4'h7,
      F_LINE_DRIVER_ENABLE   = 4'h8,
      F_WAKE   = 4'h9,
      F_VBUS   = 4'ha,
      F_BCDET  = 4'hb,
      F_BCSUSP = 4'hc,
      F_SDA    = 4'hd,
      F_SCL    = 4'he
   } gmr_func_e;

   // Allowed function set per pin, bit n = code n
   localparam logic [15:0] ALLOWED [NUM_PINS] = '{
      16'h0001, 16'h0001, 16'h01e5, 16'h0e19,
      16'h20a5, 16'h5019, 16'h0d01, 16'h0201,
      16'h0026, 16'h001a, 16'h2402, 16'h4082,
      16'h1022, 16'h0802, 16'h02e0, 16'h0502
   };

   // Factory default function per pin
   localparam logic [3:0] DEF_FUNC [NUM_PINS] = '{
      4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
      4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h6, 4'h8
   };

   // Group A pins that the serial port drives
   localparam logic [7:0]  SER_OUT_MASK = 8'h15;

   // ==========================================
   // Clock output timing
   // ==========================================
   localparam int unsigned SYS_CLK_HZ     = 40_000_000;
   localparam int unsigned CLK_OUT_MAX_HZ = 12_000_000;
   localparam int unsigned CLK_HALF_MIN_I =
      (SYS_CLK_HZ + 2 * CLK_OUT_MAX_HZ - 1) / (2 * CLK_OUT_MAX_HZ);
   localparam logic [7:0]  CLK_HALF_MIN   = 8'(CLK_HALF_MIN_I);

   // ==========================================
   // Carriers
   // ==========================================
   typedef struct packed {
      logic [15:0] o;
      logic [15:0] oe;
   } gmr_pins_s;

   typedef struct packed {
      logic [63:0] func;          // 4 bits per pin, pin 0 lowest
      logic        susp_bus_only; // 0: unconfigured or suspended
      logic [7:0]  clk_half;      // Clock output half period
   } gmr_cfg_s;

endpackage : gmr_pkg

// ==== hdl/gmr_router.sv ====
`timescale 1ns/1ps

// Function
// RL1 - Sixteen pins, two groups, independent functions
// RL2 - Selection from OTP or external EEPROM
// RL3 - Each pin limited to allowed functions
// RL4 - GPIO function driven by host software
// RL5 - Transmit activity LED output
// RL6 - Receive activity LED output
// RL7 - Combined activity LED output
// RL8 - Supply detect gates bus attach
// RL9 - Supply detect on one pin only; the code lets several pins take it and any one of them high allows attach
// RL10 - Configured indicator high once configured
// RL11 - Line driver enable while transmitting
// RL12 - Active low shutdown with two modes
// RL13 - Wakeup pin toggle leaves suspend
// RL14 - Single wakeup pin, default ring pin; the code lets several pins take it and the lowest of them wins
// RL15 - Charger detect high when detected
// RL16 - Charger shutdown inactive in charged suspend
// RL17 - Clock output configurable, at most 12MHz
// RL18 - EEPROM data and clock pins bidirectional
// RL19 - EEPROM pins open drain only
module gmr_router
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire gmr_pkg::gmr_cfg_s otp_cfg_i,
   input  wire gmr_pkg::gmr_cfg_s ee_cfg_i,
   input  wire logic              ee_present_i,
   input  wire logic              cfg_load_i,
   input  wire logic              drv_clk_sel_i,
   input  wire logic [7:0]        drv_clk_half_i,
   input  wire logic [15:0]       pin_i,
   output gmr_pkg::gmr_pins_s     pins_o,
   input  wire logic [15:0]       gpio_out_i,
   input  wire logic [15:0]       gpio_oe_i,
   output logic [15:0]            gpio_in_o,
   input  wire logic              ser_txd_i,
   input  wire logic              ser_rts_i,
   input  wire logic              ser_dtr_i,
   output logic [7:0]             ser_in_o,
   input  wire logic              tx_active_i,
   input  wire logic              rx_active_i,
   input  wire logic              tx_busy_i,
   input  wire logic              usb_configured_i,
   input  wire logic              suspended_i,
   input  wire logic              bc_detected_i,
   input  wire logic              eeprom_serial_data_i,
   input  wire logic              eeprom_serial_clock_i,
   output logic                   eeprom_serial_data_in_o,
   output logic                   eeprom_serial_clock_in_o,
   output logic                   attach_ok_o,
   output logic                   wakeup_o,
   output logic                   cfg_loaded_o
);

   // ==========================================
   // Declarations
   // ==========================================
   typedef enum logic [1:0] {
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b10
   } gmr_state_e;

   typedef gmr_pkg::gmr_cfg_s gmr_cfg_s_t;

   gmr_state_e  state_reg;
   gmr_cfg_s_t  cfg_next;
   logic [63:0] func_reg;
   logic        susp_mode_reg;
   logic [7:0]  clk_half_reg;
   logic [15:0] pin_lvl;
   logic [15:0] pin_oe;
   logic [15:0] is_vbus;
   logic [15:0] is_wake;
   logic [15:0] is_sda;
   logic [15:0] is_scl;
   logic [7:0]  ser_drv;
   logic        shutdown_output_low_lvl;
   logic        bcsusp_n_lvl;
   logic        clk_out;
   logic        wake_lvl;
   logic        wake_prev_reg;
   logic [7:0]  clk_half_sel;

   // ==========================================
   // Configuration source and legality
   // ==========================================
   // External EEPROM, when present, overrides OTP
   always_comb
   begin
      cfg_next = ee_present_i ? ee_cfg_i : otp_cfg_i; // [RL2]
   end

   // Load sequencer: pins hold defaults until a load
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= ST_WAIT;
      end
      else
      begin
         case (state_reg)
            ST_WAIT: if (cfg_load_i) state_reg <= ST_RUN;
            ST_RUN:  state_reg <= ST_RUN;
            default: state_reg <= ST_WAIT;
         endcase
      end
   end

   // Latch per pin selection, illegal codes fall back to default
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         for (int k = 0; k < 16; k++)
            func_reg[k*4 +: 4] <= gmr_pkg::DEF_FUNC[k];
         susp_mode_reg <= 1'b0;
         clk_half_reg  <= gmr_pkg::CLK_HALF_MIN;
      end
      else if (cfg_load_i)
      begin
         for (int k = 0; k < 16; k++)
            func_reg[k*4 +: 4] <=
               gmr_pkg::ALLOWED[k][cfg_next.func[k*4 +: 4]] ?
               cfg_next.func[k*4 +: 4] : gmr_pkg::DEF_FUNC[k]; // [RL1] [RL3]
         susp_mode_reg <= cfg_next.susp_bus_only;
         clk_half_reg  <= cfg_next.clk_half;
      end
   end

   assign cfg_loaded_o = (state_reg == ST_RUN);

   // ==========================================
   // Shared function levels
   // ==========================================
   // Default mode also shuts down while unconfigured
   always_comb
   begin
      shutdown_output_low_lvl   = ~(suspended_i | (~susp_mode_reg & ~usb_configured_i)); // [RL12]
      bcsusp_n_lvl = (suspended_i & bc_detected_i) ? 1'b1 : shutdown_output_low_lvl; // [RL16]
      ser_drv      = {3'b000, ser_dtr_i, 1'b0, ser_rts_i, 1'b0, ser_txd_i};
   end

   // Driver setting wins over stored configuration
   assign clk_half_sel = drv_clk_sel_i ? drv_clk_half_i : clk_half_reg;

   gmr_clk_div u_clk_div
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .half_i  (clk_half_sel),
      .clk_o   (clk_out)   // [RL17]
   );

   // ==========================================
   // Per pin output multiplexer
   // ==========================================
   for (genvar i = 0; i < 16; i++)
   begin : g_pin
      logic [3:0] f;
      assign f          = func_reg[i*4 +: 4];
      assign is_vbus[i] = (f == gmr_pkg::F_VBUS);
      assign is_wake[i] = (f == gmr_pkg::F_WAKE);
      assign is_sda[i]  = (f == gmr_pkg::F_SDA);
      assign is_scl[i]  = (f == gmr_pkg::F_SCL);

      always_comb
      begin
         pin_lvl[i] = 1'b0;
         pin_oe[i]  = 1'b1;
         case (f)
            gmr_pkg::F_SERIAL:
            begin
               pin_lvl[i] = (i < 8) ? ser_drv[i % 8] : 1'b0;
               pin_oe[i]  = (i < 8) ? gmr_pkg::SER_OUT_MASK[i % 8] : 1'b0;
            end
            gmr_pkg::F_GPIO:
            begin
               pin_lvl[i] = gpio_out_i[i]; // [RL4]
               pin_oe[i]  = gpio_oe_i[i];
            end
            gmr_pkg::F_TXLED:  pin_lvl[i] = tx_active_i; // [RL5]
            gmr_pkg::F_RXLED:  pin_lvl[i] = rx_active_i; // [RL6]
            gmr_pkg::F_TRXLED: pin_lvl[i] = tx_active_i | rx_active_i; // [RL7]
            gmr_pkg::F_CLK:    pin_lvl[i] = clk_out;
            gmr_pkg::F_SUSP:   pin_lvl[i] = shutdown_output_low_lvl;
            gmr_pkg::F_CFG:    pin_lvl[i] = usb_configured_i; // [RL10]
            gmr_pkg::F_LINE_DRIVER_ENABLE:   pin_lvl[i] = tx_busy_i; // [RL11]
            gmr_pkg::F_BCDET:  pin_lvl[i] = bc_detected_i; // [RL15]
            gmr_pkg::F_BCSUSP: pin_lvl[i] = bcsusp_n_lvl;
            // Open drain: only pull low, pull-ups make the high
            gmr_pkg::F_SDA:    pin_oe[i]  = ~eeprom_serial_data_i; // [RL18] [RL19]
            gmr_pkg::F_SCL:    pin_oe[i]  = ~eeprom_serial_clock_i; // [RL18] [RL19]
            gmr_pkg::F_WAKE,
            gmr_pkg::F_VBUS:   pin_oe[i]  = 1'b0;
            default:           pin_oe[i]  = 1'b0;
         endcase
      end

      a_func_legal : assert property (@(posedge clk_i) disable iff (!rst_n_i)
         gmr_pkg::ALLOWED[i][f]) // [RL3]
         else $error("pin holds a function outside its set");

      a_gpio_follow : assert property (@(posedge clk_i) disable iff (!rst_n_i)
         (f == gmr_pkg::F_GPIO) ##1 (f == gmr_pkg::F_GPIO) |->
         pins_o.o[i] == $past(gpio_out_i[i]) && pins_o.oe[i] == $past(gpio_oe_i[i])) // [RL4]
         else $error("gpio pin does not follow software");

      a_combined_activity_led : assert property (@(posedge clk_i) disable iff (!rst_n_i)
         (f == gmr_pkg::F_TRXLED) && rx_active_i ##1 (f == gmr_pkg::F_TRXLED)
         |-> pins_o.o[i] && pins_o.oe[i]) // [RL7]
         else $error("combined led missed receive activity");

      a_cfg_pin : assert property (@(posedge clk_i) disable iff (!rst_n_i)
         (f == gmr_pkg::F_CFG) ##1 (f == gmr_pkg::F_CFG)
         |-> pins_o.o[i] == $past(usb_configured_i)) // [RL10]
         else $error("configured indicator wrong");

      a_line_driver_enable_pin : assert property (@(posedge clk_i) disable iff (!rst_n_i)
         (f == gmr_pkg::F_LINE_DRIVER_ENABLE) && tx_busy_i ##1 (f == gmr_pkg::F_LINE_DRIVER_ENABLE)
         |-> pins_o.o[i] && pins_o.oe[i]) // [RL11]
         else $error("line driver enable not asserted");

      a_ee_odrain : assert property (@(posedge clk_i) disable iff (!rst_n_i)
         (is_sda[i] || is_scl[i]) |=> !pins_o.o[i]) // [RL19]
         else $error("eeprom pin driven high");
   end

   // ==========================================
   // Registered pin drive and input capture
   // ==========================================
   // Pins released at reset, so nothing fights the board
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         pins_o    <= '0;
         gpio_in_o <= 16'h0000;
         ser_in_o  <= 8'h00;
      end
      else
      begin
         pins_o.o  <= pin_lvl;
         pins_o.oe <= pin_oe;
         gpio_in_o <= pin_i; // [RL4]
         ser_in_o  <= pin_i[7:0];
      end
   end

   // EEPROM read back, open drain wire level
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         eeprom_serial_data_in_o <= 1'b1;
         eeprom_serial_clock_in_o <= 1'b1;
      end
      else
      begin
         eeprom_serial_data_in_o <= ~|(is_sda & ~pin_i); // [RL18]
         eeprom_serial_clock_in_o <= ~|(is_scl & ~pin_i);
      end
   end

   // ==========================================
   // Supply detect and wakeup
   // ==========================================
   // With no detect pin assigned attach is free
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         attach_ok_o <= 1'b0;
      else
         attach_ok_o <= (is_vbus == 16'h0000) | |(is_vbus & pin_i); // [RL8] [RL9]
   end

   // Lowest assigned pin wins; ring pin is the fallback
   always_comb
   begin
      wake_lvl = pin_i[gmr_pkg::PIN_A_RI]; // [RL14]
      for (int k = 15; k >= 0; k--)
         if (is_wake[k]) wake_lvl = pin_i[k];
   end

   // Any edge on the wakeup pin during suspend; the previous level
   // follows the pin through reset, so release shows no false edge
   always_ff @(posedge clk_i)
   begin
      wake_prev_reg <= wake_lvl;
      if (!rst_n_i)
         wakeup_o <= 1'b0;
      else
         wakeup_o <= suspended_i & (wake_lvl ^ wake_prev_reg); // [RL13]
   end

   // ==========================================
   // Checks
   // ==========================================
   a_attach_hold : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (is_vbus != 16'h0000) && !(|(is_vbus & pin_i)) |=> !attach_ok_o) // [RL8]
      else $error("attach allowed without supply");

   a_susp_mode : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !susp_mode_reg && !usb_configured_i |-> !shutdown_output_low_lvl) // [RL12]
      else $error("shutdown not asserted while unconfigured");

   a_bc_susp : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      suspended_i && bc_detected_i |-> bcsusp_n_lvl && !shutdown_output_low_lvl) // [RL16]
      else $error("charger shutdown not forced inactive");

   a_wake_edge : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      suspended_i && $changed(wake_lvl) |=> wakeup_o) // [RL13]
      else $error("wakeup toggle ignored");

   a_wake_quiet : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !suspended_i |=> !wakeup_o) // [RL13]
      else $error("wakeup outside suspend");

   a_cfg_src : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cfg_load_i && ee_present_i &&
      gmr_pkg::ALLOWED[2][ee_cfg_i.func[11:8]] |=>
      func_reg[11:8] == $past(ee_cfg_i.func[11:8])) // [RL2]
      else $error("eeprom selection not taken");

   c_wake : cover property (@(posedge clk_i) disable iff (!rst_n_i) wakeup_o);
   c_attach : cover property (@(posedge clk_i) disable iff (!rst_n_i)
      !attach_ok_o ##1 attach_ok_o);
   c_ee_load : cover property (@(posedge clk_i) disable iff (!rst_n_i)
      cfg_load_i && ee_present_i);
   c_bc_susp : cover property (@(posedge clk_i) disable iff (!rst_n_i)
      suspended_i && bc_detected_i);

endmodule : gmr_router

// ==== tb/gmr_pin_world.sv ====
`timescale 1ns/1ps

// ==========================================
// Board side: transceivers, LEDs, EEPROM, MCU
// ==========================================
module gmr_pin_world
(
   input  wire logic               clk_i,
   input  wire gmr_pkg::gmr_pins_s pins_i,
   input  wire logic [15:0]        ext_val_i,
   input  wire logic [15:0]        ext_oe_i,
   input  wire logic [15:0]        pull_up_i,
   output logic [15:0]             lvl_o
);
   logic [15:0] last_reg = '0;

   // Wire level; a floating line shows the inverse of its last level,
   // so a design that samples a dead line cannot match by luck
   always_comb
   begin
      for (int p = 0; p < 16; p++)
      begin
         if (pull_up_i[p])
            lvl_o[p] = !(pins_i.oe[p] && !pins_i.o[p]) &&
                       !(ext_oe_i[p] && !ext_val_i[p]);
         else if (pins_i.oe[p])
            lvl_o[p] = pins_i.o[p];
         else if (ext_oe_i[p])
            lvl_o[p] = ext_val_i[p];
         else
            lvl_o[p] = !last_reg[p];
      end
   end

   // Last seen level
   always_ff @(posedge clk_i)
      last_reg <= lvl_o;
endmodule : gmr_pin_world

// ==== tb/tb_gpio_multifunction_router.sv ====
`timescale 1ns/1ps

module tb_gpio_multifunction_router;
   // ==========================================
   // Stimulus and observed signals
   // ==========================================
   logic               clk = 1'h0;
   logic               rst_n = 1'h0;
   gmr_pkg::gmr_cfg_s  otp_cfg = '0;
   gmr_pkg::gmr_cfg_s  ee_cfg = '0;
   logic               ee_present = 1'h0;
   logic               cfg_load = 1'h0;
   logic               drv_sel = 1'h0;
   logic [7:0]         drv_half = 8'h02;
   logic [15:0]        gpo = '0, gpoe = '0, ext_val = '0, ext_oe = '1, pull = '0;
   logic               txd = 1'h0, rts = 1'h0, dtr = 1'h0, txa = 1'h0, rxa = 1'h0;
   logic               busy = 1'h0, conf = 1'h0, susp = 1'h0, bc = 1'h0;
   logic               sda = 1'h1, scl = 1'h1, mode = 1'h0;
   logic [15:0]        lvl, gpio_in;
   logic [7:0]         ser_in;
   logic               sda_in, scl_in, attach, wake, loaded;
   gmr_pkg::gmr_pins_s pins;
   int                 n_errors = 0, cmp_count = 0, fn [16];

   gmr_router u_gmr_router
   (
      .clk_i(clk), .rst_n_i(rst_n), .otp_cfg_i(otp_cfg), .ee_cfg_i(ee_cfg),
      .ee_present_i(ee_present), .cfg_load_i(cfg_load), .drv_clk_sel_i(drv_sel),
      .drv_clk_half_i(drv_half), .pin_i(lvl), .pins_o(pins), .gpio_out_i(gpo),
      .gpio_oe_i(gpoe), .gpio_in_o(gpio_in), .ser_txd_i(txd), .ser_rts_i(rts),
      .ser_dtr_i(dtr), .ser_in_o(ser_in), .tx_active_i(txa), .rx_active_i(rxa),
      .tx_busy_i(busy), .usb_configured_i(conf), .suspended_i(susp),
      .bc_detected_i(bc), .eeprom_serial_data_i(sda), .eeprom_serial_clock_i(scl), .eeprom_serial_data_in_o(sda_in),
      .eeprom_serial_clock_in_o(scl_in), .attach_ok_o(attach), .wakeup_o(wake),
      .cfg_loaded_o(loaded)
   );

   gmr_pin_world u_gmr_pin_world
   (
      .clk_i(clk), .pins_i(pins), .ext_val_i(ext_val), .ext_oe_i(ext_oe),
      .pull_up_i(pull), .lvl_o(lvl)
   );

   // 40 MHz clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end

   // Hang guard, far beyond the expected run
   initial
   begin
      #400000;
      n_errors++;
      tally_and_finish();
   end

   // ==========================================
   // Checking and reference model
   // ==========================================
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // Expected {care about o, oe, o} of one pin
   function automatic logic [2:0] want(int q);
      logic s;
      s = !(susp || (!mode && !conf));
      case (fn[q])
         0: return gmr_pkg::SER_OUT_MASK[q] ? {2'h3, q == 0 ? txd : (q == 2 ? rts : dtr)} : 3'h0;
         1: return {gpoe[q], gpoe[q], gpo[q] & gpoe[q]};
         2: return {2'h3, txa};
         3: return {2'h3, rxa};
         4: return {2'h3, txa | rxa};
         5: return 3'h2;
         6: return {2'h3, s};
         7: return {2'h3, conf};
         8: return {2'h3, busy};
         11: return {2'h3, bc};
         12: return {2'h3, s | (susp & bc)};
         13: return {!sda, !sda, 1'h0};
         14: return {!scl, !scl, 1'h0};
         default: return 3'h0;
      endcase
   endfunction : want

   task automatic set_defaults;
      for (int q = 0; q < 16; q++)
         fn[q] = gmr_pkg::DEF_FUNC[q];
   endtask : set_defaults

   // One random cycle of inputs, then pins, captures, attach and EEPROM read back compared
   task automatic step;
      logic [15:0] p;
      logic [2:0]  w;
      logic        at, sd, sc;
      @(posedge clk);
      {txd, rts, dtr, txa, rxa, busy, conf, susp, bc, sda, scl} <= 11'($urandom);
      {gpo, gpoe} <= $urandom;
      {ext_val, ext_oe} <= $urandom;
      {drv_sel, drv_half} <= 9'($urandom);
      @(negedge clk);
      p = lvl;
      {at, sd, sc} = 3'h7;
      @(negedge clk);
      for (int q = 0; q < 16; q++)
      begin
         w = want(q);
         chk({pins.oe[q], pins.o[q] & w[2]}, {w[1], w[0]});
         if (fn[q] == 10) at = p[q];
         if (fn[q] == 13) sd = p[q];
         if (fn[q] == 14) sc = p[q];
      end
      chk({gpio_in, ser_in}, {p, p[7:0]});
      chk({attach, sda_in, scl_in}, {at, sd, sc});
   endtask : step

   // Load through the chosen source; the other source carries junk
   task automatic load_cfg(input logic [63:0] f, input logic m, input logic [7:0] h,
                           input logic ee);
      gmr_pkg::gmr_cfg_s c, j;
      c = {f, m, h};
      j = 73'({$urandom, $urandom, $urandom});
      @(posedge clk);
      ee_present <= ee;
      otp_cfg <= ee ? j : c;
      ee_cfg <= ee ? c : j;
      cfg_load <= 1'h1;
      @(posedge clk);
      cfg_load <= 1'h0;
      mode <= m;
      for (int q = 0; q < 16; q++)
         pull[q] <= (fn[q] == 13 || fn[q] == 14);
      @(negedge clk);
      chk(loaded, 1'h1);
      @(posedge clk);
   endtask : load_cfg

   // Random codes, disallowed ones included; single-use functions kept unique
   task automatic rand_cfg;
      logic [63:0] f;
      logic [15:0] used;
      int          r, c;
      used = '0;
      for (int q = 0; q < 16; q++)
      begin
         r = $urandom_range(15);
         c = gmr_pkg::ALLOWED[q][r] ? r : gmr_pkg::DEF_FUNC[q];
         if (c inside {9, 10, 13, 14} && used[c])
         begin
            r = gmr_pkg::DEF_FUNC[q];
            c = r;
         end
         used[c] = 1'h1;
         fn[q] = c;
         f[4*q +: 4] = 4'(r);
      end
      load_cfg(f, 1'($urandom), 8'($urandom), 1'($urandom));
   endtask : rand_cfg

   // Toggle one pin and count wake pulses
   task automatic wake_case(input logic [3:0] b6, input int tp, input logic s,
                            input logic [3:0] n_exp);
      logic [3:0] n;
      set_defaults();
      fn[14] = b6;
      load_cfg({4'h8, b6, 24'h111111, 32'h0}, 1'h0, 8'h02, 1'h0);
      susp <= s;
      ext_oe <= '1;
      ext_val <= '0;
      repeat (4) @(posedge clk);
      ext_val[tp] <= 1'h1;
      n = '0;
      repeat (4)
      begin
         @(negedge clk);
         n += {3'h0, wake};
      end
      chk(n, n_exp);
   endtask : wake_case

   // Measure one half period of the clock output on the first group B pin
   task automatic clk_case(input logic sel, input logic [7:0] h, input int n_exp);
      logic v;
      int   k, n;
      set_defaults();
      fn[8] = 5;
      load_cfg({32'h86111115, 32'h0}, 1'h0, 8'h01, 1'h0);
      drv_sel <= sel;
      drv_half <= h;
      repeat (3) @(negedge clk);
      v = pins.o[8];
      for (k = 0; k < 40 && pins.o[8] === v; k++)
         @(negedge clk);
      v = pins.o[8];
      for (n = 0; n < 40 && pins.o[8] === v; n++)
         @(negedge clk);
      chk({pins.oe[8], 8'(n)}, {1'h1, 8'(n_exp)});
   endtask : clk_case

   // ==========================================
   // Main sequence
   // ==========================================
   initial
   begin
      void'($urandom(43027));
      set_defaults();
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk(32'(pins), 32'h0);
      chk({gpio_in, ser_in, sda_in, scl_in, attach, wake, loaded}, {24'h0, 5'h18});
      @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      // Factory defaults before any load
      repeat (4) step();
      repeat (60)
      begin
         rand_cfg();
         repeat (4) step();
      end
      wake_case(4'h6, 7, 1'h1, 4'h1);
      wake_case(4'h6, 7, 1'h0, 4'h0);
      wake_case(4'h9, 14, 1'h1, 4'h1);
      wake_case(4'h9, 7, 1'h1, 4'h0);
      // Half period never below two cycles, so at most 10 MHz
      clk_case(1'h0, 8'h07, 2);
      clk_case(1'h1, 8'h05, 5);
      clk_case(1'h1, 8'h01, 2);
      tally_and_finish();
   end
endmodule : tb_gpio_multifunction_router
